//--- logic/asps_cfg.svh
// Constants for the automatic stage program sequencer
`ifndef ASPS_CFG_SVH
`define ASPS_CFG_SVH

// Mode selector codes
`define ASPS_MODE_OFF 3'h0
`define ASPS_MODE_SGL_R 3'h1
`define ASPS_MODE_CON_R 3'h2
`define ASPS_MODE_HLD_R 3'h3
`define ASPS_MODE_SGL_F 3'h4
`define ASPS_MODE_CON_F 3'h5
`define ASPS_MODE_HLD_F 3'h6

// Direction codes
`define ASPS_DIR_STOP 2'h0
`define ASPS_DIR_FWD 2'h1
`define ASPS_DIR_REV 2'h2

// Setting selectors on the write port
`define ASPS_SEL_FREQ 2'h0
`define ASPS_SEL_TIME 2'h1
`define ASPS_SEL_DIR 2'h2

// Ranges: 400.00 Hz in 0.01 Hz, 6000.0 s in 0.1 s
`define ASPS_FREQ_MAX 16'h9C40
`define ASPS_TIME_MAX 16'hEA60

`define ASPS_STAGE_FIRST 4'h0
`define ASPS_STAGE_LAST 4'hF
`define ASPS_STAGES 16

// Timing: one duration step is 0.1 s, clock period 50 ns
`define ASPS_STEP_NS 100000000
`define ASPS_MCLK_NS 50
`define ASPS_TICK_CYCLES (`ASPS_STEP_NS / `ASPS_MCLK_NS)

`endif

//--- logic/asps_pkg.sv
// Types for the automatic stage program sequencer
package asps_pkg;
  typedef enum logic [1:0] {
    ASPS_IDLE,
    ASPS_RUN,
    ASPS_HOLD,
    ASPS_DONE
  } asps_state_t;
endpackage

//--- logic/asps_tick_gen.sv
// Duration step tick generator (one pulse per 0.1 s)
`timescale 1ns/10ps
`default_nettype none
`include "asps_cfg.svh"
module asps_tick_gen #(
  parameter int unsigned TICK_CYCLES = `ASPS_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clr,
  output logic tick
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg + 32'h1;
    if (clr || (cnt_reg >= TICK_CYCLES - 1)) begin
      cnt_next = 32'h0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = !clr && (cnt_reg >= TICK_CYCLES - 1);
endmodule // asps_tick_gen
`default_nettype wire

//--- logic/asps_sequencer.sv
// Automatic stage program sequencer: sixteen timed stages driving frequency and direction
//
// Operation
// - Mode 0 inactive; modes 1 and 4 run the stage list once then stop.
// - Modes 2 and 5 repeat the stage cycle without end.
// - Modes 3 and 6 run one cycle, then hold last stage frequency.
// - Modes 1 to 3 resume the interrupted stage when run returns.
// - Modes 4 to 6 restart from stage 0 when run returns.
// - Wobble or PID enabled forces the sequencer inactive.
// - All stage durations zero makes the sequencer inactive.
// - Multi-step speed select inputs are ignored while the sequencer is enabled.
// - Stage 0 frequency comes from the multi-step speed 0 setting.
// - Stage transitions use the general accel and decel times.
// - Frequency per stage 1..15, 0.00 to 400.00 Hz, 0.01 Hz steps.
// - Duration per stage 0..15, 0.0 to 6000.0 s, 0.1 s steps.
// - Direction per stage: 0 stop, 1 forward, 2 reverse.
// - Each stage drives its own duration and direction; stages 1..15 also their own frequency.
`timescale 1ns/10ps
`default_nettype none
`include "asps_cfg.svh"
module asps_sequencer #(
  parameter int unsigned TICK_CYCLES = `ASPS_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [2:0] mode_sel,
  input wire logic wobble_en,
  input wire logic pid_en,
  input wire logic run_cmd,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_sel,
  input wire logic [3:0] cfg_stage,
  input wire logic [15:0] cfg_data,
  input wire logic [15:0] ms0_freq,
  input wire logic [3:0] ms_sel_in,
  output logic [3:0] ms_sel_out,
  output logic ramp_general,
  output logic seq_active,
  output logic [15:0] freq_ref,
  output logic [1:0] dir_cmd,
  output logic [3:0] stage_idx,
  output logic cycle_done
);
  // ----------------------------------------------------------------
  // Stage settings
  // ----------------------------------------------------------------
  logic [15:0] freq_mem [1:15];
  logic [15:0] time_mem [0:15];
  logic [1:0] dir_mem [0:15];
  logic [15:0] data_clamp;

  always_comb begin
    data_clamp = cfg_data;
    if (cfg_sel == `ASPS_SEL_FREQ && cfg_data > `ASPS_FREQ_MAX) begin
      data_clamp = `ASPS_FREQ_MAX;
    end else if (cfg_sel == `ASPS_SEL_TIME && cfg_data > `ASPS_TIME_MAX) begin
      data_clamp = `ASPS_TIME_MAX;
    end else if (cfg_sel == `ASPS_SEL_DIR && cfg_data[1:0] > `ASPS_DIR_REV) begin
      data_clamp = {14'h0, `ASPS_DIR_STOP};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `ASPS_STAGES; i++) begin
        time_mem[i] <= 16'h0;
        dir_mem[i] <= `ASPS_DIR_STOP;
        if (i > 0) begin
          freq_mem[i] <= 16'h0;
        end
      end
    end else if (cfg_wr) begin
      if (cfg_sel == `ASPS_SEL_FREQ && cfg_stage != `ASPS_STAGE_FIRST) begin
        freq_mem[cfg_stage] <= data_clamp;
      end else if (cfg_sel == `ASPS_SEL_TIME) begin
        time_mem[cfg_stage] <= data_clamp;
      end else if (cfg_sel == `ASPS_SEL_DIR) begin
        dir_mem[cfg_stage] <= data_clamp[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable and mode decode
  // ----------------------------------------------------------------
  logic run_s1_reg;
  logic run_s2_reg;
  logic any_time;
  logic mode_ok;
  logic seq_en;
  logic m_single;
  logic m_cont;
  logic m_hold;
  logic m_resume;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
    end else begin
      run_s1_reg <= run_cmd;
      run_s2_reg <= run_s1_reg;
    end
  end

  always_comb begin
    any_time = 1'b0;
    for (int i = 0; i < `ASPS_STAGES; i++) begin
      any_time = any_time | (time_mem[i] != 16'h0);
    end
  end

  assign m_single = (mode_sel == `ASPS_MODE_SGL_R) || (mode_sel == `ASPS_MODE_SGL_F);
  assign m_cont = (mode_sel == `ASPS_MODE_CON_R) || (mode_sel == `ASPS_MODE_CON_F);
  assign m_hold = (mode_sel == `ASPS_MODE_HLD_R) || (mode_sel == `ASPS_MODE_HLD_F);
  assign m_resume = (mode_sel >= `ASPS_MODE_SGL_R) && (mode_sel <= `ASPS_MODE_HLD_R);
  assign mode_ok = m_single || m_cont || m_hold;
  assign seq_en = mode_ok && !wobble_en && !pid_en && any_time;
  assign ms_sel_out = seq_en ? 4'h0 : ms_sel_in;
  assign ramp_general = seq_en;

  // ----------------------------------------------------------------
  // Stage timer
  // ----------------------------------------------------------------
  asps_pkg::asps_state_t state_reg;
  asps_pkg::asps_state_t state_next;
  logic [3:0] stage_reg;
  logic [3:0] stage_next;
  logic [15:0] elapsed_reg;
  logic [15:0] elapsed_next;
  logic tick;
  logic tick_clr;
  logic stage_end;

  assign tick_clr = (state_reg != asps_pkg::ASPS_RUN);

  asps_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .clr(tick_clr),
    .tick(tick)
  );

  // A zero-length stage ends at once and is skipped
  assign stage_end = (time_mem[stage_reg] == 16'h0) ||
                     (tick && (elapsed_reg + 16'h1 >= time_mem[stage_reg]));

  // ----------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    stage_next = stage_reg;
    elapsed_next = elapsed_reg;
    if (!seq_en) begin
      state_next = asps_pkg::ASPS_IDLE;
      stage_next = `ASPS_STAGE_FIRST;
      elapsed_next = 16'h0;
    end else if (!run_s2_reg) begin
      state_next = asps_pkg::ASPS_IDLE;
      if (!m_resume || state_reg == asps_pkg::ASPS_DONE ||
          state_reg == asps_pkg::ASPS_HOLD) begin
        stage_next = `ASPS_STAGE_FIRST;
        elapsed_next = 16'h0;
      end
    end else begin
      case (state_reg)
        asps_pkg::ASPS_IDLE: begin
          state_next = asps_pkg::ASPS_RUN;
        end
        asps_pkg::ASPS_RUN: begin
          if (tick) begin
            elapsed_next = elapsed_reg + 16'h1;
          end
          if (stage_end) begin
            elapsed_next = 16'h0;
            if (stage_reg != `ASPS_STAGE_LAST) begin
              stage_next = stage_reg + 4'h1;
            end else if (m_cont) begin
              stage_next = `ASPS_STAGE_FIRST;
            end else if (m_hold) begin
              state_next = asps_pkg::ASPS_HOLD;
            end else begin
              state_next = asps_pkg::ASPS_DONE;
            end
          end
        end
        asps_pkg::ASPS_HOLD: begin
          state_next = asps_pkg::ASPS_HOLD;
        end
        default: begin
          state_next = asps_pkg::ASPS_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= asps_pkg::ASPS_IDLE;
      stage_reg <= `ASPS_STAGE_FIRST;
      elapsed_reg <= 16'h0;
    end else begin
      state_reg <= state_next;
      stage_reg <= stage_next;
      elapsed_reg <= elapsed_next;
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  logic [15:0] stage_freq;
  logic [15:0] freq_next;
  logic [1:0] dir_next;
  logic [15:0] freq_reg;
  logic [1:0] dir_reg;
  logic active_reg;
  logic done_reg;

  assign stage_freq = (stage_reg == `ASPS_STAGE_FIRST) ? ms0_freq : freq_mem[stage_reg];

  always_comb begin
    freq_next = freq_reg;
    dir_next = `ASPS_DIR_STOP;
    if (state_reg == asps_pkg::ASPS_RUN || state_reg == asps_pkg::ASPS_HOLD) begin
      freq_next = stage_freq;
      dir_next = dir_mem[stage_reg];
    end
    // Stopped: frequency reference keeps the last value as the restart speed
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      freq_reg <= 16'h0;
      dir_reg <= `ASPS_DIR_STOP;
      active_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      freq_reg <= freq_next;
      dir_reg <= dir_next;
      active_reg <= seq_en;
      done_reg <= (state_next == asps_pkg::ASPS_DONE) || (state_next == asps_pkg::ASPS_HOLD);
    end
  end

  assign freq_ref = freq_reg;
  assign dir_cmd = dir_reg;
  assign seq_active = active_reg;
  assign cycle_done = done_reg;
  assign stage_idx = stage_reg;
endmodule // asps_sequencer
`default_nettype wire

//--- sim/asps_seq_assertions.sv
// Port checks for the stage program sequencer
`timescale 1ns/10ps
`default_nettype none
module asps_seq_assertions #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [2:0] mode_sel,
  input wire logic wobble_en,
  input wire logic pid_en,
  input wire logic run_cmd,
  input wire logic [3:0] ms_sel_in,
  input wire logic [3:0] ms_sel_out,
  input wire logic ramp_general,
  input wire logic seq_active,
  input wire logic [15:0] freq_ref,
  input wire logic [1:0] dir_cmd,
  input wire logic [3:0] stage_idx,
  input wire logic cycle_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_ms_gate_zero: assert property (ramp_general |-> ms_sel_out == 4'h0)
    else $error("select not gated");
  a_ms_gate_pass: assert property (!ramp_general |-> ms_sel_out == ms_sel_in)
    else $error("select not passed");
  a_force_off: assert property (wobble_en || pid_en |=> !seq_active)
    else $error("active with wobble or pid");
  a_mode_off: assert property (mode_sel == 3'h0 |=> !seq_active)
    else $error("active in mode 0");
  a_idle_stop: assert property (!seq_active [*3] |-> dir_cmd == 2'h0)
    else $error("direction while inactive");
  a_dir_code: assert property (dir_cmd != 2'h3)
    else $error("bad direction code");
  a_freq_range: assert property (freq_ref <= 16'h9C40)
    else $error("frequency over range");
  a_stop_halt: assert property (!run_cmd [*6] |-> dir_cmd == 2'h0)
    else $error("direction after stop");
  a_stage_step: assert property ($changed(stage_idx) |->
    stage_idx == $past(stage_idx) + 4'h1 || stage_idx == 4'h0)
    else $error("stage skipped");
  c_wrap: cover property (stage_idx == 4'hF ##1 stage_idx == 4'h0);
  c_hold: cover property (cycle_done && dir_cmd != 2'h0);
  c_start: cover property ($rose(seq_active));
endmodule // asps_seq_assertions
bind asps_sequencer asps_seq_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);
`default_nettype wire

//--- sim/asps_drive_model.sv
// Output stage model: motor frequency follows the reference on a ramp
`timescale 1ns/10ps
`default_nettype none
module asps_drive_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ramp_general,
  input wire logic [15:0] freq_ref,
  input wire logic [1:0] dir_cmd,
  output int out_freq
);
  int tgt;
  int step;
  // Stop code ramps to zero; general ramp step while sequencing, no overshoot
  always @(posedge mclk or negedge rstn) begin
    tgt = dir_cmd == 2'h0 ? 0 : int'(freq_ref);
    step = ramp_general ? 2000 : 500;
    if (!rstn)
      out_freq <= 0;
    else if (out_freq < tgt - step)
      out_freq <= out_freq + step;
    else if (out_freq > tgt + step)
      out_freq <= out_freq - step;
    else
      out_freq <= tgt;
  end
endmodule // asps_drive_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the stage program sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int TK = 4;
  logic mclk, rstn, wobble_en, pid_en, run_cmd, cfg_wr, ramp_general, seq_active, cycle_done;
  logic [2:0] mode_sel;
  logic [1:0] cfg_sel, dir_cmd;
  logic [3:0] cfg_stage, ms_sel_in, ms_sel_out, stage_idx;
  logic [15:0] cfg_data, ms0_freq, freq_ref;
  int errors, total_checks, cur, len, i, out_freq;
  int fq[16], tm[16], dr[16];
  bit mon;
  asps_sequencer #(.TICK_CYCLES(TK)) i_dut (.*);
  asps_drive_model i_drv (.mclk, .rstn, .ramp_general, .freq_ref, .dir_cmd, .out_freq(out_freq));
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [1:0] s, input int st, input int d);
    @(posedge mclk);
    cfg_wr <= 1'h1;
    cfg_sel <= s;
    cfg_stage <= 4'(st);
    cfg_data <= 16'(d);
    @(posedge mclk);
    cfg_wr <= 1'h0;
  endtask
  task automatic go(input logic [2:0] m, input logic r, input int n);
    @(posedge mclk);
    mode_sel <= m;
    run_cmd <= r;
    ms_sel_in <= 4'($urandom);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Reference model of stage order, length and outputs
  always @(negedge mclk) if (mon) begin
    if (stage_idx !== 4'(cur)) begin
      chk(stage_idx, 16'((cur + 1) % 16), "order");
      if (len < 500)
        chk(16'(tm[cur] > 0 ? len > (tm[cur] - 1) * TK && len <= tm[cur] * TK + 1 : len <= 2),
          16'h1, "length");
      cur = stage_idx;
      len = 0;
    end
    len++;
    if (len == 3 && tm[cur] > 0) begin
      chk(dir_cmd, 16'(dr[cur]), "dir");
      if (dr[cur] != 0)
        chk(freq_ref, cur > 0 ? 16'(fq[cur]) : ms0_freq, "freq");
    end
  end
  initial begin
    {wobble_en, pid_en, run_cmd, cfg_wr, mon, rstn} = '0;
    mode_sel = 3'h0;
    cfg_sel = 2'h0;
    cfg_stage = 4'h0;
    cfg_data = 16'h0000;
    void'($urandom(31));
    ms_sel_in = 4'($urandom);
    ms0_freq = 16'($urandom % 40001);
    repeat (3) @(posedge mclk);
    rstn <= 1'h1;
    chk(ms_sel_out, ms_sel_in, "pass");
    for (i = 0; i < 16; i++) begin
      fq[i] = $urandom % 40001;
      dr[i] = i < 3 ? i : (i == 15 ? 1 : $urandom % 3);
      tm[i] = i < 3 || i == 15 ? (i == 1 ? 5 : 1) : 0;
      wr(2'h0, i, fq[i]);
      wr(2'h1, i, tm[i]);
      wr(2'h2, i, dr[i]);
    end
    cur = 0;
    len = 999;
    mon = 1'h1;
    go(3'h2, 1'h1, 110);
    mon = 1'h0;
    go(3'h2, 1'h0, 8);
    $display("continuous test end");
    go(3'h1, 1'h1, 0);
    for (i = 0; i < 300 && cycle_done !== 1'h1; i++) @(negedge mclk);
    go(3'h1, 1'h1, 2);
    chk(cycle_done, 16'h1, "single done");
    chk(dir_cmd, 16'h0, "single");
    chk(freq_ref, 16'(fq[15]), "restart speed");
    go(3'h1, 1'h0, 8);
    go(3'h3, 1'h1, 0);
    for (i = 0; i < 300 && cycle_done !== 1'h1; i++) @(negedge mclk);
    go(3'h3, 1'h1, 24);
    chk(cycle_done, 16'h1, "hold done");
    chk(dir_cmd, 16'(dr[15]), "hold dir");
    chk(freq_ref, 16'(fq[15]), "hold freq");
    chk(16'(out_freq), 16'(fq[15]), "motor speed");
    go(3'h3, 1'h0, 8);
    $display("single and hold test end");
    go(3'h4, 1'h1, 0);
    for (i = 0; i < 300 && stage_idx !== 4'h1; i++) @(negedge mclk);
    go(3'h4, 1'h1, 8);
    go(3'h4, 1'h0, 8);
    chk(stage_idx, 16'h0, "restart");
    go(3'h1, 1'h1, 0);
    for (i = 0; i < 300 && stage_idx !== 4'h1; i++) @(negedge mclk);
    go(3'h1, 1'h1, 8);
    go(3'h1, 1'h0, 8);
    chk(stage_idx, 16'h1, "kept");
    go(3'h1, 1'h1, 6);
    chk(stage_idx, 16'h1, "resume");
    go(3'h1, 1'h1, 6);
    chk(stage_idx, 16'h2, "resume time");
    $display("resume test end");
    go(3'h5, 1'h1, 4);
    chk(seq_active, 16'h1, "on");
    chk(ramp_general, 16'h1, "ramp on");
    chk(ms_sel_out, 16'h0, "select gated");
    wobble_en <= 1'h1;
    go(3'h6, 1'h1, 3);
    chk(seq_active, 16'h0, "wobble");
    chk(ramp_general, 16'h0, "ramp off");
    chk(ms_sel_out, 16'(ms_sel_in), "select passed");
    chk(stage_idx, 16'h0, "wobble stage");
    chk(dir_cmd, 16'h0, "wobble dir");
    {wobble_en, pid_en} <= 2'h1;
    go(3'h6, 1'h1, 3);
    chk(seq_active, 16'h0, "pid");
    pid_en <= 1'h0;
    go(3'h0, 1'h1, 3);
    chk(seq_active, 16'h0, "mode 0");
    go(3'h7, 1'h1, 3);
    chk(seq_active, 16'h0, "mode 7");
    for (i = 0; i < 16; i++) wr(2'h1, i, 0);
    go(3'h2, 1'h1, 4);
    chk(seq_active, 16'h0, "zero time");
    $display("inhibit test end");
    results();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results();
  end
endmodule // testbench
`default_nettype wire
